// [spf_baud_gen.v]
/*
 Bit-rate tick generator: turns a four-bit baud code into a one-cycle tick at the chosen rate.
 Assumes the code is already checked against the reserved values by the caller.
*/
`include "spf_defs.vh"

module spf_baud_gen #(
	parameter CLK_HZ = `SPF_CLK_HZ
) (
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_clk_en,
	input wire [3:0] i_baud_code,
	output reg o_baud_tick
);
	reg [23:0] cnt_ff;
	reg [31:0] div_full;
	reg [3:0] code_ff;
	// The divider is cut to 24 bits, which holds the slowest rate for clocks up to about 1.8 GHz.
	wire [23:0] div = div_full[23:0];

	always @* begin
		case (i_baud_code) // see [R04]
			4'h1: div_full = CLK_HZ / 110;
			4'h2: div_full = CLK_HZ / 150;
			4'h3: div_full = CLK_HZ / 300;
			4'h4: div_full = CLK_HZ / 600;
			4'h5: div_full = CLK_HZ / 1200;
			4'h6: div_full = CLK_HZ / 2400;
			4'h7: div_full = CLK_HZ / 4800;
			4'h8: div_full = CLK_HZ / 9600;
			4'h9: div_full = CLK_HZ / 19200;
			4'hA: div_full = CLK_HZ / 38400;
			4'hB: div_full = CLK_HZ / 57600;
			4'hC: div_full = CLK_HZ / 115200;
			4'hD: div_full = CLK_HZ / 500000;
			4'hE: div_full = CLK_HZ / 32150;
			default: div_full = CLK_HZ / 9600;
		endcase
	end

	// A rate change restarts the count so the first bit at the new rate is never short.
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cnt_ff <= 24'h00_0000;
			code_ff <= 4'h8;
			o_baud_tick <= 1'b0;
		end else if (i_clk_en) begin
			code_ff <= i_baud_code;
			if (code_ff != i_baud_code || cnt_ff >= div - 24'h00_0001) begin
				cnt_ff <= 24'h00_0000;
				o_baud_tick <= (code_ff == i_baud_code);
			end else begin
				cnt_ff <= cnt_ff + 24'h00_0001;
				o_baud_tick <= 1'b0;
			end
		end
	end
endmodule // spf_baud_gen

// [spf_defs.vh]
/*
 Constants for the controller serial port format and control block: register indices, field positions,
 reset values, baud codes, status bits and timing counts.
 Assumes it is included by its bare name from every design file that needs it.
*/
// How it works
// [R01] Format bit 0 picks 7 data bits when clear and 8 when set, and RTU framing always forces 8.
// [R02] Format bits 1 and 2 pick parity: 00 none, 01 odd, 11 even.
// [R03] Format bit 3 picks one stop bit when clear and two when set.
// [R04] Format bits 4 to 7 hold a baud code where 1 to E map to 110 up to 115200, then 500000 and 32150 baud.
// [R05] Software is expected not to choose a rate above 115 kbps for this port.
// [R06] Format bits 8, 9 and 10 enable start, first end and second end characters, each from its own register.
// [R07] When the hold flag is set at the first program scan, the live framing is reloaded from the format word.
// [R08] The framing select flag picks ASCII when clear and RTU when set.
// [R09] If no reply comes within the timeout limit, the timeout flag is set.
// [R10] The port answers as a slave at the station address, or acts as a master issuing requests.
// [R11] Slave use needs only the format; master use needs software to issue read, write or read-write commands.
// [R12] A changed format stays in effect when the controller leaves run mode.
// [R13] After a power cycle the port returns to 9600 baud, 7 data bits, even parity and 1 stop bit.
// [R14] The station address is shared with the USB programming port; the panel port keeps its own.
// [R15] Every communication error sets a status flag that software can read.
// [R16] All three ports run at the same time without disturbing one another.
// [R17] A reserved baud code of 0 or F keeps the previous rate.
`ifndef SPF_DEFS_VH
`define SPF_DEFS_VH

`define SPF_ADDR_W 4
`define SPF_DATA_W 16

`define SPF_REG_FORMAT 4'h0
`define SPF_REG_CTRL 4'h1
`define SPF_REG_STATION 4'h2
`define SPF_REG_TIMEOUT 4'h3
`define SPF_REG_START_CHAR 4'h4
`define SPF_REG_END1_CHAR 4'h5
`define SPF_REG_END2_CHAR 4'h6
`define SPF_REG_COMMAND 4'h7
`define SPF_REG_STATUS 4'h8
`define SPF_REG_MASK 4'h9
`define SPF_REG_ACTIVE 4'hA

`define SPF_FMT_DATA8 0
`define SPF_FMT_PAR_EN 1
`define SPF_FMT_PAR_EVEN 2
`define SPF_FMT_STOP2 3
`define SPF_FMT_BAUD_LO 4
`define SPF_FMT_BAUD_HI 7
`define SPF_FMT_START_EN 8
`define SPF_FMT_END1_EN 9
`define SPF_FMT_END2_EN 10
`define SPF_FMT_USED_MASK 16'h07FF
`define SPF_FMT_RESET 16'h0086

`define SPF_CTRL_HOLD 0
`define SPF_CTRL_RTU 1
`define SPF_CTRL_MASTER 2
`define SPF_CTRL_MASK 16'h0007

`define SPF_CMD_NONE 2'h0
`define SPF_CMD_READ 2'h1
`define SPF_CMD_WRITE 2'h2
`define SPF_CMD_READWRITE 2'h3

`define SPF_ST_DONE 0
`define SPF_ST_TIMEOUT 1
`define SPF_ST_RX_ERR 2
`define SPF_ST_PARAM_ERR 3
`define SPF_ST_W 4

`define SPF_BAUD_RSVD_LO 4'h0
`define SPF_BAUD_RSVD_HI 4'hF

`define SPF_CLK_HZ 250000000
`define SPF_TIMEOUT_UNIT_MS 1
`define SPF_TIMEOUT_UNIT_CYC ((`SPF_CLK_HZ / 1000) * `SPF_TIMEOUT_UNIT_MS)

`endif

// [spf_port_ctrl.v]
/*
 Format and control logic of the controller serial port: register file, live framing, slave address match,
 master command sequencing, reply timeout and error status with an interrupt.
 Assumes a serializer on the same clock consumes the framing outputs and reports replies and addresses.
*/
`include "spf_defs.vh"

module spf_port_ctrl #(
	parameter CLK_HZ = `SPF_CLK_HZ,
	parameter TIMEOUT_UNIT_CYC = `SPF_TIMEOUT_UNIT_CYC
) (
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_clk_en,
	input wire [3:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [15:0] o_rdata,
	input wire i_first_scan,
	input wire i_run,
	input wire i_rx_addr_valid,
	input wire [7:0] i_rx_addr,
	input wire i_reply_valid,
	input wire i_reply_bad,
	output wire o_addr_match,
	output reg o_req_valid,
	output reg [1:0] o_req_cmd,
	output wire o_master_mode,
	output wire o_rtu_mode,
	output wire o_data_8bit,
	output wire o_parity_en,
	output wire o_parity_odd,
	output wire o_two_stop,
	output wire o_baud_tick,
	output wire o_start_en,
	output wire o_end1_en,
	output wire o_end2_en,
	output reg [7:0] o_start_char,
	output reg [7:0] o_end1_char,
	output reg [7:0] o_end2_char,
	output wire [7:0] o_usb_station_addr,
	output wire o_timeout_flag,
	output wire o_irq
);
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	reg [15:0] format_ff;
	reg [15:0] active_ff;
	reg [15:0] nxt_active;
	reg [2:0] ctrl_ff;
	reg [7:0] station_ff;
	reg [15:0] limit_ff;
	reg [3:0] status_ff;
	reg [3:0] nxt_status;
	reg [3:0] mask_ff;
	reg state_ff;
	reg nxt_state;
	reg [3:0] ev;
	reg run_ff;

	wire wr_format = i_wr && i_addr == `SPF_REG_FORMAT;
	wire wr_cmd = i_wr && i_addr == `SPF_REG_COMMAND;
	wire rd_status = i_rd && i_addr == `SPF_REG_STATUS;
	wire [3:0] fmt_baud = format_ff[`SPF_FMT_BAUD_HI:`SPF_FMT_BAUD_LO];
	wire baud_rsvd = fmt_baud == `SPF_BAUD_RSVD_LO || fmt_baud == `SPF_BAUD_RSVD_HI;
	wire timer_expired;
	wire cmd_go = wr_cmd && o_master_mode && state_ff == ST_IDLE;
	wire cmd_valid = i_wdata[1:0] != `SPF_CMD_NONE;

	// Software registers; the format word powers up to the documented default format.
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			format_ff <= `SPF_FMT_RESET; // see [R13]
			ctrl_ff <= 3'h0;
			station_ff <= 8'h01;
			limit_ff <= 16'h0000;
			o_start_char <= 8'h00;
			o_end1_char <= 8'h00;
			o_end2_char <= 8'h00;
			mask_ff <= 4'h0;
		end else if (i_clk_en && i_wr) begin
			case (i_addr)
				`SPF_REG_FORMAT: begin
					format_ff <= i_wdata & `SPF_FMT_USED_MASK; // see [R06]
				end
				`SPF_REG_CTRL: begin
					ctrl_ff <= i_wdata[2:0];
				end
				`SPF_REG_STATION: begin
					station_ff <= i_wdata[7:0];
				end
				`SPF_REG_TIMEOUT: begin
					limit_ff <= i_wdata;
				end
				`SPF_REG_START_CHAR: begin
					o_start_char <= i_wdata[7:0]; // see [R06]
				end
				`SPF_REG_END1_CHAR: begin
					o_end1_char <= i_wdata[7:0];
				end
				`SPF_REG_END2_CHAR: begin
					o_end2_char <= i_wdata[7:0];
				end
				`SPF_REG_MASK: begin
					mask_ff <= i_wdata[3:0];
				end
				default: begin
					mask_ff <= mask_ff;
				end
			endcase
		end
	end

	// The live framing only moves at a first scan with the hold flag set. Leaving run mode never touches it,
	// so a format loaded once survives a stop; only a reset brings back the default.
	always @* begin
		nxt_active = active_ff;
		if (i_first_scan && ctrl_ff[`SPF_CTRL_HOLD]) begin // see [R07]
			nxt_active = format_ff; // see [R12]
			if (baud_rsvd) begin
				nxt_active[`SPF_FMT_BAUD_HI:`SPF_FMT_BAUD_LO] =
					active_ff[`SPF_FMT_BAUD_HI:`SPF_FMT_BAUD_LO]; // see [R17]
			end
		end
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			active_ff <= `SPF_FMT_RESET; // see [R13]
			run_ff <= 1'b0;
		end else if (i_clk_en) begin
			active_ff <= nxt_active;
			run_ff <= i_run; // see [R12]
		end
	end

	assign o_rtu_mode = ctrl_ff[`SPF_CTRL_RTU]; // see [R08]
	assign o_data_8bit = active_ff[`SPF_FMT_DATA8] | o_rtu_mode; // see [R01]
	assign o_parity_en = active_ff[`SPF_FMT_PAR_EN]; // see [R02]
	assign o_parity_odd = active_ff[`SPF_FMT_PAR_EN] & ~active_ff[`SPF_FMT_PAR_EVEN]; // see [R02]
	assign o_two_stop = active_ff[`SPF_FMT_STOP2]; // see [R03]
	assign o_start_en = active_ff[`SPF_FMT_START_EN]; // see [R06]
	assign o_end1_en = active_ff[`SPF_FMT_END1_EN];
	assign o_end2_en = active_ff[`SPF_FMT_END2_EN];

	spf_baud_gen #(
		.CLK_HZ(CLK_HZ)
	) u_baud (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_baud_code(active_ff[`SPF_FMT_BAUD_HI:`SPF_FMT_BAUD_LO]), // see [R04]
		.o_baud_tick(o_baud_tick)
	);

	// Slave side: the address is the same one the USB programming port answers to. The panel port has its own
	// logic and address, and nothing here is shared with it, so the ports cannot stall each other.
	assign o_master_mode = ctrl_ff[`SPF_CTRL_MASTER]; // see [R10]
	assign o_addr_match = ~o_master_mode & i_rx_addr_valid & (i_rx_addr == station_ff); // see [R10]
	assign o_usb_station_addr = station_ff; // see [R14] [R16]

	// Master side: one outstanding request at a time, guarded by the reply timer.
	always @* begin
		nxt_state = state_ff;
		ev = 4'h0;
		case (state_ff)
			ST_IDLE: begin
				if (cmd_go) begin // see [R11]
					if (cmd_valid && !baud_rsvd) begin
						nxt_state = ST_WAIT;
					end else begin
						ev[`SPF_ST_PARAM_ERR] = 1'b1; // see [R15]
					end
				end else if (wr_cmd && !o_master_mode) begin
					ev[`SPF_ST_PARAM_ERR] = 1'b1;
				end
			end
			ST_WAIT: begin
				if (i_reply_valid) begin
					nxt_state = ST_IDLE;
					ev[`SPF_ST_DONE] = ~i_reply_bad;
					ev[`SPF_ST_RX_ERR] = i_reply_bad; // see [R15]
				end else if (timer_expired) begin
					nxt_state = ST_IDLE;
					ev[`SPF_ST_TIMEOUT] = 1'b1; // see [R09]
				end
				if (wr_cmd) begin
					ev[`SPF_ST_PARAM_ERR] = 1'b1;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_ff <= ST_IDLE;
			o_req_valid <= 1'b0;
			o_req_cmd <= `SPF_CMD_NONE;
		end else if (i_clk_en) begin
			state_ff <= nxt_state;
			o_req_valid <= state_ff == ST_IDLE && nxt_state == ST_WAIT;
			if (state_ff == ST_IDLE && nxt_state == ST_WAIT) begin
				o_req_cmd <= i_wdata[1:0]; // see [R11]
			end
		end
	end

	spf_timeout #(
		.UNIT_CYC(TIMEOUT_UNIT_CYC)
	) u_timeout (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_start(state_ff == ST_IDLE && nxt_state == ST_WAIT),
		.i_stop(state_ff == ST_WAIT && i_reply_valid),
		.i_limit(limit_ff),
		.o_expired(timer_expired)
	);

	// Status is cleared by reading it, but an event in the same cycle as that read still lands.
	always @* begin
		nxt_status = status_ff;
		if (rd_status) begin
			nxt_status = 4'h0;
		end
		nxt_status = nxt_status | ev; // see [R15]
	end

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			status_ff <= 4'h0;
		end else if (i_clk_en) begin
			status_ff <= nxt_status;
		end
	end

	assign o_timeout_flag = status_ff[`SPF_ST_TIMEOUT]; // see [R09]
	assign o_irq = |(status_ff & mask_ff);

	// Read data stands for exactly the cycle after the strobe; unmapped addresses and idle cycles read zero.
	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 16'h0000;
		end else if (i_clk_en) begin
			o_rdata <= 16'h0000;
			if (i_rd) begin
				case (i_addr)
					`SPF_REG_FORMAT: o_rdata <= format_ff;
					`SPF_REG_CTRL: o_rdata <= {13'h0000, ctrl_ff};
					`SPF_REG_STATION: o_rdata <= {8'h00, station_ff};
					`SPF_REG_TIMEOUT: o_rdata <= limit_ff;
					`SPF_REG_START_CHAR: o_rdata <= {8'h00, o_start_char};
					`SPF_REG_END1_CHAR: o_rdata <= {8'h00, o_end1_char};
					`SPF_REG_END2_CHAR: o_rdata <= {8'h00, o_end2_char};
					`SPF_REG_COMMAND: o_rdata <= {13'h0000, state_ff, o_req_cmd};
					`SPF_REG_STATUS: o_rdata <= {12'h000, status_ff};
					`SPF_REG_MASK: o_rdata <= {12'h000, mask_ff};
					`SPF_REG_ACTIVE: o_rdata <= {active_ff[15:2], active_ff[1], o_data_8bit};
					default: o_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// The run level is registered but drives nothing; software cannot read it, and it only feeds this unused wire.
	wire unused_run = run_ff & wr_format;
endmodule // spf_port_ctrl

// [spf_port_ctrl_chk.sv]
/*
 Port assertions for the serial port format and control block.
 Assumes one clock with a synchronous active-low reset; bound to every instance below.
*/
`include "spf_defs.vh"

module spf_port_ctrl_chk #(
	parameter int TIMEOUT_UNIT_CYC = `SPF_TIMEOUT_UNIT_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_first_scan,
	input wire logic i_rx_addr_valid,
	input wire logic [7:0] i_rx_addr,
	input wire logic i_reply_valid,
	input wire logic o_addr_match,
	input wire logic o_req_valid,
	input wire logic [1:0] o_req_cmd,
	input wire logic o_master_mode,
	input wire logic o_rtu_mode,
	input wire logic o_data_8bit,
	input wire logic o_parity_en,
	input wire logic o_parity_odd,
	input wire logic o_two_stop,
	input wire logic o_baud_tick,
	input wire logic o_start_en,
	input wire logic o_end1_en,
	input wire logic o_end2_en,
	input wire logic [7:0] o_usb_station_addr,
	input wire logic o_timeout_flag,
	input wire logic o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Cycles since the last request; a timeout can never come sooner than one unit after it.
	int wait_cnt_ff;
	always @(posedge i_sys_clk) begin
		if (!i_rst_n || o_req_valid) begin
			wait_cnt_ff <= 0;
		end else if (wait_cnt_ff < 1000000) begin
			wait_cnt_ff <= wait_cnt_ff + 1;
		end
	end
	sequence s_cmd_write;
		i_wr && i_addr == `SPF_REG_COMMAND;
	endsequence
	sequence s_quiet;
		!o_req_valid [*2];
	endsequence
	chk_rtu_eight_bits: assert property (o_rtu_mode |-> o_data_8bit)
		else $error("rtu framing without eight data bits");
	chk_odd_needs_par: assert property (o_parity_odd |-> o_parity_en)
		else $error("odd parity without parity enabled");
	chk_live_frame: assert property (!$past(i_first_scan) |->
		$stable({o_parity_en, o_parity_odd, o_two_stop, o_start_en, o_end1_en, o_end2_en}))
		else $error("live framing changed without a first scan");
	chk_slave_match: assert property (o_addr_match ==
		(i_rx_addr_valid && !o_master_mode && i_rx_addr == o_usb_station_addr))
		else $error("address match disagrees with station");
	chk_req_cause: assert property (o_req_valid |-> $past(i_wr) &&
		$past(i_addr) == `SPF_REG_COMMAND && o_req_cmd == $past(i_wdata[1:0]) && o_req_cmd != 2'h0)
		else $error("request without a matching command write");
	chk_req_pulse: assert property (s_cmd_write ##1 o_req_valid |=> s_quiet)
		else $error("request not a single pulse");
	chk_timeout_wait: assert property ($rose(o_timeout_flag) |-> wait_cnt_ff >= TIMEOUT_UNIT_CYC)
		else $error("timeout flag set too early");
	chk_flag_sticky: assert property ($fell(o_timeout_flag) |->
		$past(i_rd) && $past(i_addr) == `SPF_REG_STATUS)
		else $error("timeout flag cleared without status read");
	chk_irq_cause: assert property ($rose(o_irq) |-> $past(i_wr) || $past(i_reply_valid) ||
		$rose(o_timeout_flag))
		else $error("interrupt rose without an event");
	chk_irq_clear: assert property ($fell(o_irq) |-> $past(i_rd) || $past(i_wr))
		else $error("interrupt fell without an access");
	chk_tick_pulse: assert property (o_baud_tick |=> !o_baud_tick)
		else $error("baud tick longer than one cycle");
endmodule // spf_port_ctrl_chk

bind spf_port_ctrl spf_port_ctrl_chk #(.TIMEOUT_UNIT_CYC(TIMEOUT_UNIT_CYC)) u_chk (.i_sys_clk, .i_rst_n,
	.i_addr, .i_wdata, .i_wr, .i_rd, .i_first_scan, .i_rx_addr_valid, .i_rx_addr, .i_reply_valid, .o_addr_match,
	.o_req_valid, .o_req_cmd, .o_master_mode, .o_rtu_mode, .o_data_8bit, .o_parity_en, .o_parity_odd,
	.o_two_stop, .o_baud_tick, .o_start_en, .o_end1_en, .o_end2_en, .o_usb_station_addr, .o_timeout_flag, .o_irq);

// [spf_serial_peer.sv]
/*
 Remote station model: answers each read or write request after a fixed delay.
 Assumes read requests get good replies, writes bad ones and read-write none, so a timeout can be provoked.
*/
module spf_serial_peer #(
	parameter int DELAY = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_req_valid,
	input wire logic [1:0] i_req_cmd,
	output logic o_reply_valid = 1'b0,
	output logic o_reply_bad = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_ff;
	logic [1:0] cmd_ff;
	always @(posedge i_sys_clk) begin
		o_reply_valid <= 1'b0;
		o_reply_bad <= 1'b0;
		if (!i_rst_n) begin
			cnt_ff <= 0;
		end else if (i_req_valid) begin
			cnt_ff <= DELAY;
			cmd_ff <= i_req_cmd;
		end else if (cnt_ff == 1) begin
			cnt_ff <= 0;
			o_reply_valid <= cmd_ff != 2'h3;
			o_reply_bad <= cmd_ff == 2'h2;
		end else if (cnt_ff != 0) begin
			cnt_ff <= cnt_ff - 1;
		end
	end
endmodule // spf_serial_peer

// [spf_timeout.v]
/*
 Reply timeout counter: counts whole units of time while armed and pulses once when the limit is reached.
 Assumes start and stop are single-cycle pulses from the same clock.
*/
`include "spf_defs.vh"

module spf_timeout #(
	parameter UNIT_CYC = `SPF_TIMEOUT_UNIT_CYC
) (
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_clk_en,
	input wire i_start,
	input wire i_stop,
	input wire [15:0] i_limit,
	output reg o_expired
);
	reg [23:0] unit_ff;
	reg [15:0] units_ff;
	reg armed_ff;

	always @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			unit_ff <= 24'h00_0000;
			units_ff <= 16'h0000;
			armed_ff <= 1'b0;
			o_expired <= 1'b0;
		end else if (i_clk_en) begin
			o_expired <= 1'b0;
			if (i_start) begin
				unit_ff <= 24'h00_0000;
				units_ff <= 16'h0000;
				armed_ff <= 1'b1;
			end else if (i_stop) begin
				armed_ff <= 1'b0;
			end else if (armed_ff) begin
				if (unit_ff == UNIT_CYC[23:0] - 24'h00_0001) begin
					unit_ff <= 24'h00_0000;
					if (units_ff + 16'h0001 >= i_limit) begin // see [R09]
						o_expired <= 1'b1;
						armed_ff <= 1'b0;
					end
					units_ff <= units_ff + 16'h0001;
				end else begin
					unit_ff <= unit_ff + 24'h00_0001;
				end
			end
		end
	end
endmodule // spf_timeout

// [test_serial_port_format_control.sv]
/*
 Self-checking bench for the serial port format and control block.
 Assumes the remote station model and the bound checker; clock scaled down so bit periods stay short.
*/
`include "spf_defs.vh"

module test_serial_port_format_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 0, i_rst_n = 0, i_clk_en = 1, i_wr = 0, i_rd = 0, i_first_scan = 0, i_run = 1;
	logic i_rx_addr_valid = 0, i_reply_valid, i_reply_bad;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000, o_rdata;
	logic [7:0] i_rx_addr = 8'h00, o_start_char, o_end1_char, o_end2_char, o_usb_station_addr;
	logic o_addr_match, o_req_valid, o_master_mode, o_rtu_mode, o_data_8bit, o_parity_en, o_parity_odd;
	logic o_two_stop, o_baud_tick, o_start_en, o_end1_en, o_end2_en, o_timeout_flag, o_irq;
	logic [1:0] o_req_cmd;
	int err_total = 0, tests_run = 0, cyc = 0, j, k;
	// Code 7 stands in for the 500000 code, which software must not pick for this port.
	int baud_code[7] = '{8, 9, 10, 11, 12, 7, 14};
	int rate[7] = '{250, 125, 62, 41, 20, 500, 74};
	logic [15:0] st_exp[3] = '{16'h0009, 16'h0004, 16'h0002};

	spf_port_ctrl #(.CLK_HZ(2400000), .TIMEOUT_UNIT_CYC(10)) u_dut (.i_sys_clk, .i_rst_n, .i_clk_en, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .i_first_scan, .i_run, .i_rx_addr_valid, .i_rx_addr, .i_reply_valid,
		.i_reply_bad, .o_addr_match, .o_req_valid, .o_req_cmd, .o_master_mode, .o_rtu_mode, .o_data_8bit,
		.o_parity_en, .o_parity_odd, .o_two_stop, .o_baud_tick, .o_start_en, .o_end1_en, .o_end2_en,
		.o_start_char, .o_end1_char, .o_end2_char, .o_usb_station_addr, .o_timeout_flag, .o_irq);
	spf_serial_peer u_peer (.i_sys_clk, .i_rst_n, .i_req_valid(o_req_valid), .i_req_cmd(o_req_cmd),
		.o_reply_valid(i_reply_valid), .o_reply_bad(i_reply_bad));

	always #2 i_sys_clk = ~i_sys_clk;

	task print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Strobes rise after one edge and drop after the next, so every access is exactly one cycle.
	task acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		#1;
	endtask

	task wr(input logic [3:0] a, input logic [15:0] d);
		acc(1'b1, a, d);
	endtask

	task rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
		acc(1'b0, a, 16'h0000);
		chk(o_rdata, exp, nm);
	endtask

	task scan();
		@(posedge i_sys_clk);
		i_first_scan <= 1'b1;
		@(posedge i_sys_clk);
		i_first_scan <= 1'b0;
		#1;
	endtask

	task meas(input int exp);
		int n;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(posedge i_sys_clk);
				#1;
				n++;
			end while (o_baud_tick !== 1'b1 && n < 600);
		end
		chk(n >= exp - 1 && n <= exp + 1, 1, "baud period");
	endtask

	initial begin
		repeat (3) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		rd(`SPF_REG_FORMAT, 16'h0086, "format reset");
		rd(`SPF_REG_ACTIVE, 16'h0086, "live reset");
		rd(4'hF, 16'h0000, "unmapped");
		chk({o_data_8bit, o_parity_en, o_parity_odd, o_two_stop}, 4'b0100, "reset frame");
		chk(o_usb_station_addr, 8'h01, "usb station");
		$display("test reset done");
		wr(`SPF_REG_CTRL, 16'h0001);
		for (j = 0; j < 16; j++) begin
			wr(`SPF_REG_FORMAT, 16'hF780 | 16'(j));
			rd(`SPF_REG_FORMAT, 16'h0780 | 16'(j), "format word");
			scan();
			chk({o_data_8bit, o_parity_en, o_parity_odd, o_two_stop, o_start_en, o_end1_en, o_end2_en},
				{j[0], j[1], j[1] & ~j[2], j[3], 3'b111}, "frame");
		end
		wr(`SPF_REG_CTRL, 16'h0000);
		wr(`SPF_REG_FORMAT, 16'h0086);
		scan();
		i_run <= 1'b0;
		repeat (5) @(posedge i_sys_clk);
		#1;
		chk({o_data_8bit, o_parity_en, o_parity_odd, o_two_stop}, 4'b1101, "held frame");
		wr(`SPF_REG_CTRL, 16'h0001);
		scan();
		wr(`SPF_REG_CTRL, 16'h0003);
		chk({o_rtu_mode, o_data_8bit}, 2'b11, "rtu length");
		rd(`SPF_REG_ACTIVE, 16'h0087, "live rtu");
		wr(`SPF_REG_CTRL, 16'h0001);
		chk({o_rtu_mode, o_data_8bit}, 2'b00, "ascii length");
		i_run <= 1'b1;
		$display("test format done");
		wr(`SPF_REG_START_CHAR, 16'h003A);
		wr(`SPF_REG_END1_CHAR, 16'h000D);
		wr(`SPF_REG_END2_CHAR, 16'h000A);
		chk({o_start_char, o_end1_char}, 16'h3A0D, "chars");
		rd(`SPF_REG_END2_CHAR, 16'h000A, "end char");
		chk(o_end2_char, 8'h0A, "end2 char");
		$display("test chars done");
		wr(`SPF_REG_CTRL, 16'h0004);
		chk(o_master_mode, 1, "master mode");
		wr(`SPF_REG_TIMEOUT, 16'h0002);
		rd(`SPF_REG_TIMEOUT, 16'h0002, "limit");
		wr(`SPF_REG_MASK, 16'h0000);
		wr(`SPF_REG_COMMAND, 16'h0000);
		chk(o_irq, 0, "masked irq");
		rd(`SPF_REG_STATUS, 16'h0008, "code zero");
		wr(`SPF_REG_MASK, 16'h000F);
		for (k = 1; k < 4; k++) begin
			wr(`SPF_REG_COMMAND, 16'(k));
			chk({o_req_valid, o_req_cmd}, {1'b1, k[1:0]}, "request");
			if (k == 1) begin
				wr(`SPF_REG_COMMAND, 16'h0002);
			end
			repeat (15) @(posedge i_sys_clk);
			#1;
			chk(o_timeout_flag, 0, "early timeout");
			repeat (15) @(posedge i_sys_clk);
			#1;
			chk({o_irq, o_timeout_flag}, {1'b1, k == 3}, "event");
			rd(`SPF_REG_STATUS, st_exp[k - 1], "status");
			chk({o_irq, o_timeout_flag}, 2'b00, "cleared");
		end
		rd(`SPF_REG_COMMAND, 16'h0003, "last command");
		wr(`SPF_REG_CTRL, 16'h0000);
		chk(o_master_mode, 0, "slave mode");
		wr(`SPF_REG_COMMAND, 16'h0001);
		chk(o_req_valid, 0, "slave request");
		rd(`SPF_REG_STATUS, 16'h0008, "slave refusal");
		$display("test master done");
		wr(`SPF_REG_STATION, 16'h002A);
		chk(o_usb_station_addr, 8'h2A, "shared station");
		for (k = 0; k < 3; k++) begin
			if (k == 2) begin
				wr(`SPF_REG_CTRL, 16'h0004);
			end
			@(posedge i_sys_clk);
			i_rx_addr_valid <= 1'b1;
			i_rx_addr <= (k == 1) ? 8'h2B : 8'h2A;
			#1;
			chk(o_addr_match, k == 0, "addr match");
			@(posedge i_sys_clk);
			i_rx_addr_valid <= 1'b0;
		end
		$display("test slave done");
		wr(`SPF_REG_CTRL, 16'h0001);
		for (j = 0; j < 7; j++) begin
			wr(`SPF_REG_FORMAT, 16'((baud_code[j] << 4) | 6));
			scan();
			meas(rate[j]);
		end
		wr(`SPF_REG_FORMAT, 16'h00F6);
		scan();
		meas(74);
		wr(`SPF_REG_FORMAT, 16'h0006);
		scan();
		meas(74);
		// A write to the station register while the clock enable is low must leave it untouched.
		@(posedge i_sys_clk);
		i_clk_en <= 1'b0;
		wr(`SPF_REG_STATION, 16'h0055);
		@(posedge i_sys_clk);
		i_clk_en <= 1'b1;
		rd(`SPF_REG_STATION, 16'h002A, "frozen write");
		chk(o_usb_station_addr, 8'h2A, "frozen station");
		$display("test baud done");
		print_verdict();
	end
endmodule // test_serial_port_format_control
